// >>> dv/fio_io_model.sv
`timescale 1ns/10ps
module fio_io_model (
    // Pin levels and presence
    input wire logic [15:0] pins,
    input wire logic modulePresent,
    // Data to the controller
    output logic [15:0] moduleIn
);
    // Empty slot shows inverted pins, never a clean value
    assign moduleIn = modulePresent ? pins : ~pins;
endmodule : fio_io_model

// >>> dv/fio_overlay_props.sv
`timescale 1ns/10ps
module fio_overlay_props #(
    parameter int WIDTH = fio_pkg::POINTS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Control inputs
    input wire logic inForceEn,
    input wire logic outForceEn,
    input wire logic inRefresh,
    input wire logic outRefresh,
    input wire logic pointRemote,
    input wire logic moduleDigital,
    input wire logic immediate_io_refresh_instr,
    input wire logic immIsOutput,
    // Data and status
    input wire logic [WIDTH-1:0] outImage,
    input wire logic [WIDTH-1:0] inImage,
    input wire logic [WIDTH-1:0] moduleOut,
    input wire logic moduleOutStrobe,
    input wire logic force_active_indicator,
    input wire logic immRejected
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Immediate output transfer request
    sequence immOut_s;
        immediate_io_refresh_instr && moduleDigital && immIsOutput;
    endsequence
    chk_imm_out: assert property (immOut_s |=> moduleOutStrobe && moduleOut == $past(outImage))
        else $error("immediate output wrong");
    chk_out_strobe: assert property (outRefresh |=> moduleOutStrobe) else $error("strobe missing");
    chk_no_strobe: assert property (!outRefresh && !immediate_io_refresh_instr |=> !moduleOutStrobe)
        else $error("stray strobe");
    chk_imm_reject: assert property (immediate_io_refresh_instr && !moduleDigital |=> immRejected)
        else $error("reject missing");
    chk_no_reject: assert property (!immediate_io_refresh_instr |=> !immRejected) else $error("stray reject");
    chk_remote_out: assert property (outRefresh && (pointRemote || !outForceEn) && !immediate_io_refresh_instr
        |=> moduleOut == $past(outImage)) else $error("unforced output altered");
    chk_in_hold: assert property (!inRefresh && !immediate_io_refresh_instr |=> $stable(inImage))
        else $error("input image moved");
    chk_indic_off: assert property (!inForceEn && !outForceEn |-> !force_active_indicator)
        else $error("indicator without enable");
endmodule : fio_overlay_props
bind fio_overlay fio_overlay_props #(
    .WIDTH(WIDTH)
) u_fio_overlay_props (
    .clock(clock),
    .sys_rst(sys_rst),
    .inForceEn(inForceEn),
    .outForceEn(outForceEn),
    .inRefresh(inRefresh),
    .outRefresh(outRefresh),
    .pointRemote(pointRemote),
    .moduleDigital(moduleDigital),
    .immediate_io_refresh_instr(immediate_io_refresh_instr),
    .immIsOutput(immIsOutput),
    .outImage(outImage),
    .inImage(inImage),
    .moduleOut(moduleOut),
    .moduleOutStrobe(moduleOutStrobe),
    .force_active_indicator(force_active_indicator),
    .immRejected(immRejected)
);

// >>> dv/tb.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin num_errors++; \
    $display("Error %s exp %h got %h", n, e, s); end end
module tb;
    // Design and bench signals
    logic clock = 1'h0, sys_rst = 1'h1, inForceEn, outForceEn, inRefresh, outRefresh, pointRemote, modulePresent;
    logic moduleDigital, immediate_io_refresh_instr, immIsOutput, moduleOutStrobe, force_active_indicator;
    logic immRejected, eStb, eRej, imm;
    logic [15:0] moduleIn, moduleOut, inImage, outImage, pins, fl, dt, eIn, eOut, raw;
    logic [31:0] r = 32'hB3224D80;
    fio_pkg::fio_setreq_t setReq;
    int num_errors = 0, num_checks = 0, i;
    fio_overlay u_fio_overlay (
        .clock(clock),
        .sys_rst(sys_rst),
        .setReq(setReq),
        .inForceEn(inForceEn),
        .outForceEn(outForceEn),
        .inRefresh(inRefresh),
        .outRefresh(outRefresh),
        .pointRemote(pointRemote),
        .modulePresent(modulePresent),
        .moduleDigital(moduleDigital),
        .immediate_io_refresh_instr(immediate_io_refresh_instr),
        .immIsOutput(immIsOutput),
        .moduleIn(moduleIn),
        .moduleOut(moduleOut),
        .moduleOutStrobe(moduleOutStrobe),
        .outImage(outImage),
        .inImage(inImage),
        .force_active_indicator(force_active_indicator),
        .immRejected(immRejected)
    );
    fio_io_model u_fio_io_model (
        .pins(pins),
        .modulePresent(modulePresent),
        .moduleIn(moduleIn)
    );
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim
    // Clock
    initial forever #5 clock = ~clock;
    // Watchdog
    initial begin
        #60000;
        num_errors++;
        end_sim();
    end
    // Random stimulus against the reference model
    initial begin
        {inForceEn, outForceEn, inRefresh, outRefresh, pointRemote, modulePresent, moduleDigital} = '0;
        {immediate_io_refresh_instr, immIsOutput, pins, outImage, setReq, fl, dt, eIn, eOut, eStb, eRej} = '0;
        repeat (2) @(posedge clock);
        for (i = 0; i < 3000; i++) begin
            @(negedge clock);
            `CHK("inImage", eIn, inImage)
            `CHK("moduleOut", eOut, moduleOut)
            `CHK("strobe", eStb, moduleOutStrobe)
            `CHK("reject", eRej, immRejected)
            `CHK("indicator", |fl & (inForceEn | outForceEn), force_active_indicator)
            r = lfsr(r);
            {inForceEn, outForceEn, inRefresh, outRefresh, pointRemote, modulePresent, moduleDigital} = r[6:0];
            imm = r[7] & r[8];
            immIsOutput = r[9];
            immediate_io_refresh_instr = imm;
            setReq = {fio_pkg::fio_cmd_t'(r[12:10] == 3'h0 ? 2'h2 : {1'h0, r[13]}), 3'h0, r[18:14], r[20:19]};
            r = lfsr(r);
            pins = r[15:0];
            outImage = r[31:16];
            sys_rst = (i % 700 == 699);
            raw = modulePresent ? pins : 16'h0;
            // Expected outputs at the next edge, settings applied after
            if (sys_rst) {fl, dt, eIn, eOut, eStb, eRej} = '0;
            else begin
                eRej = imm & !moduleDigital;
                eStb = outRefresh | (imm & moduleDigital & immIsOutput);
                if (imm & moduleDigital & immIsOutput) eOut = outImage;
                else if (outRefresh) eOut = (outForceEn & !pointRemote) ? (outImage & ~fl | dt & fl) : outImage;
                if (imm & moduleDigital & !immIsOutput) eIn = raw;
                else if (inRefresh) eIn = (inForceEn & !pointRemote) ? (raw & ~fl | dt & fl) : raw;
                if (setReq.cmd == fio_pkg::FIO_CMD_SET && setReq.point < 8'h10) begin
                    {fl[setReq.point[3:0]], dt[setReq.point[3:0]]} = setReq.setting;
                end else if (setReq.cmd == fio_pkg::FIO_CMD_CLR_ALL) {fl, dt} = '0;
            end
        end
        end_sim();
    end
endmodule : tb

// >>> logic/fio_force_mux.sv
`timescale 1ns/10ps
module fio_force_mux #(
    parameter int WIDTH = fio_pkg::POINTS
) (
    // Raw value and force state
    input wire logic [WIDTH-1:0] rawVal,
    input wire logic [WIDTH-1:0] flags,
    input wire logic [WIDTH-1:0] datas,
    input wire logic enable,
    // Substituted value
    output logic [WIDTH-1:0] outVal
);
    // Refuse an empty word
    if (WIDTH < 1) begin : g_width_bad
        $error("fio_force_mux: WIDTH must be at least one");
    end

    // Forced points take force data, others pass through
    always_comb begin
        outVal = enable ? ((rawVal & ~flags) | (datas & flags)) : rawVal;
    end
endmodule : fio_force_mux

// >>> logic/fio_force_store.sv
`timescale 1ns/10ps
module fio_force_store #(
    parameter int WIDTH = fio_pkg::POINTS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Settings command
    input wire fio_pkg::fio_setreq_t req,
    // Stored settings
    output logic [WIDTH-1:0] flags_q,
    output logic [WIDTH-1:0] data_q
);
    // Points the command field can address
    localparam int POINT_SPAN = 1 << $bits(req.point);
    // Index bits this word width needs
    localparam int IDX_W = (WIDTH > 1) ? $clog2(WIDTH) : 1;

    // Refuse widths the point field cannot reach
    if (WIDTH < 1 || WIDTH > POINT_SPAN) begin : g_width_bad
        $error("fio_force_store: WIDTH outside the addressable point range");
    end

    logic hit;
    logic [IDX_W-1:0] idx;

    // Only points inside the word are written
    assign hit = (int'(req.point) < WIDTH);
    assign idx = req.point[IDX_W-1:0];

    // Force flag and data storage, cleared by overall reset or the clear-all command
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            flags_q <= WIDTH'(fio_pkg::FORCE_RST);
            data_q <= WIDTH'(fio_pkg::FORCE_RST);
        end else if (req.cmd == fio_pkg::FIO_CMD_CLR_ALL) begin
            flags_q <= '0;
            data_q <= '0;
        end else if (req.cmd == fio_pkg::FIO_CMD_SET && hit) begin
            flags_q[idx] <= req.setting.flag;
            data_q[idx] <= req.setting.data;
        end
    end
endmodule : fio_force_store

// >>> logic/fio_overlay.sv
`timescale 1ns/10ps
// How it works
// - Input refresh writes forced values in place of module input.
// - Output refresh after the scan sends forced values to output modules.
// - Output image is never changed by forcing.
// - Flag plus data one forces 1; flag alone forces 0.
// - Separate input and output global enables gate all forcing.
// - Settings survive everything except overall reset and the clear-all command.
// - Overall reset clears every force flag and data bit.
// - Forced inputs apply even with no module present.
// - Indicator lights when any force flag is set and either enable is high.
// - Remote points bypass forcing entirely.
// - Refresh mode transfers all inputs at once before the scan and all outputs after it.
// - Immediate refresh transfers at once and overrides forcing.
// - Immediate access only for digital modules.
module fio_overlay #(
    parameter int WIDTH = fio_pkg::POINTS
) (
    // Clock and overall reset
    input wire logic clock,
    input wire logic sys_rst,
    // Force settings
    input wire fio_pkg::fio_setreq_t setReq,
    input wire logic inForceEn,
    input wire logic outForceEn,
    // Scan control
    input wire logic inRefresh,
    input wire logic outRefresh,
    input wire logic pointRemote,
    input wire logic modulePresent,
    input wire logic moduleDigital,
    // Immediate refresh instruction
    input wire logic immediate_io_refresh_instr,
    input wire logic immIsOutput,
    // Module side
    input wire logic [WIDTH-1:0] moduleIn,
    output logic [WIDTH-1:0] moduleOut,
    output logic moduleOutStrobe,
    // Image side
    input wire logic [WIDTH-1:0] outImage,
    output logic [WIDTH-1:0] inImage,
    // Status
    output logic force_active_indicator,
    output logic immRejected
);
    // Points the settings command can address
    localparam int POINT_SPAN = 1 << $bits(setReq.point);

    // Refuse widths the point field cannot reach
    if (WIDTH < 1 || WIDTH > POINT_SPAN) begin : g_width_bad
        $error("fio_overlay: WIDTH outside the addressable point range");
    end

    // Forcing is live only with its enable and a local word
    function automatic logic forceLive(input logic enable, input logic remote);
        return enable && !remote;
    endfunction : forceLive

    // Immediate transfer in one direction, digital modules only
    function automatic logic immGoes(input logic instr, input logic digital, input logic isOut, input logic wantOut);
        return instr && digital && (isOut == wantOut);
    endfunction : immGoes

    // Stored force settings
    logic [WIDTH-1:0] flags;
    logic [WIDTH-1:0] datas;
    // Raw and substituted words
    logic [WIDTH-1:0] inRaw;
    logic [WIDTH-1:0] inSub;
    logic [WIDTH-1:0] outSub;
    // Force gates per direction
    logic inForceLive;
    logic outForceLive;
    // Transfer decodes
    logic immInGo;
    logic immOutGo;
    logic immBad;
    logic outLoad;
    // Indicator terms
    logic anyFlag;
    logic anyEnable;
    // Registered outputs
    logic [WIDTH-1:0] inImage_q;
    logic [WIDTH-1:0] moduleOut_q;
    logic strobe_q;
    logic rej_q;

    // Settings store, cleared by overall reset or the clear-all command
    fio_force_store #(
        .WIDTH(WIDTH)
    ) store (
        .clock(clock),
        .sys_rst(sys_rst),
        .req(setReq),
        .flags_q(flags),
        .data_q(datas)
    );

    // Absent module reads as zero but forcing still applies
    assign inRaw = modulePresent ? moduleIn : '0;

    // Remote words bypass forcing in both directions
    assign inForceLive = forceLive(inForceEn, pointRemote);
    assign outForceLive = forceLive(outForceEn, pointRemote);

    // Input substitution ahead of the image
    fio_force_mux #(
        .WIDTH(WIDTH)
    ) inMux (
        .rawVal(inRaw),
        .flags(flags),
        .datas(datas),
        .enable(inForceLive),
        .outVal(inSub)
    );

    // Output substitution on the way to the modules
    fio_force_mux #(
        .WIDTH(WIDTH)
    ) outMux (
        .rawVal(outImage),
        .flags(flags),
        .datas(datas),
        .enable(outForceLive),
        .outVal(outSub)
    );

    // Immediate transfers by direction; other modules refused
    assign immInGo = immGoes(immediate_io_refresh_instr, moduleDigital, immIsOutput, 1'b0);
    assign immOutGo = immGoes(immediate_io_refresh_instr, moduleDigital, immIsOutput, 1'b1);
    assign immBad = immediate_io_refresh_instr && !moduleDigital;
    assign outLoad = immOutGo || outRefresh;

    // Input image: immediate reads raw, refresh reads substituted
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            inImage_q <= '0;
        end else if (immInGo) begin
            inImage_q <= inRaw;
        end else if (inRefresh) begin
            inImage_q <= inSub;
        end
    end

    // Output data: image only read, forced copy sent on refresh, plain image on immediate
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            moduleOut_q <= '0;
        end else if (immOutGo) begin
            moduleOut_q <= outImage;
        end else if (outRefresh) begin
            moduleOut_q <= outSub;
        end
    end

    // One strobe per word sent to the output modules
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= outLoad;
        end
    end

    // Refusal pulse for immediate access on other modules
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rej_q <= 1'b0;
        end else begin
            rej_q <= immBad;
        end
    end

    // Indicator: any stored flag while either enable is high
    assign anyFlag = |flags;
    assign anyEnable = inForceEn || outForceEn;
    assign force_active_indicator = anyFlag && anyEnable;

    // Registered data to the ports
    assign inImage = inImage_q;
    assign moduleOut = moduleOut_q;
    assign moduleOutStrobe = strobe_q;
    assign immRejected = rej_q;
endmodule : fio_overlay

// >>> pkg/fio_pkg.sv
package fio_pkg;
    // Point count per local image word, default word width
    localparam int POINTS = 16;
    // Reset value of stored force settings
    localparam logic [15:0] FORCE_RST = 16'h0000;
    // Command codes on the settings port
    typedef enum logic [1:0] {
        FIO_CMD_NONE,
        FIO_CMD_SET,
        FIO_CMD_CLR_ALL
    } fio_cmd_t;
    // One point's force setting
    typedef struct packed {
        logic flag;
        logic data;
    } fio_force_t;
    // Settings command bundle
    typedef struct packed {
        fio_cmd_t cmd;
        logic [7:0] point;
        fio_force_t setting;
    } fio_setreq_t;
endpackage : fio_pkg
